// ==== rtl/adcseq_top.v ====
`timescale 1ns/1ps
`include "adcseq_defines.vh"

module adcseq_top (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Avalon-MM slave
    input wire [`ADCSEQ_AW-1:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWritedata,
    input wire [3:0] avsByteenable,
    output reg [31:0] avsReaddata,
    output wire avsWaitrequest,
    // Analog front end
    output reg sampleEnable,
    output wire [3:0] channelSelect,
    output wire [9:0] dacCode,
    input wire compIn,
    output wire [5:0] portConfig,
    // System
    input wire sleepActive,
    input wire rcTick,
    input wire specialEventTrigger
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ACQ = 2'h1;
    localparam [1:0] ST_CONV = 2'h2;
    localparam [1:0] ST_WAIT = 2'h3;

    // Control zero
    reg converterOn;
    reg goFlag;
    reg [3:0] chanSel;
    // Control one
    reg [5:0] cfgBits;
    // Control two
    reg fmtRight;
    reg [2:0] acqSel;
    reg [2:0] clkSel;
    // Result pair
    reg [7:0] resHigh;
    reg [7:0] resLow;
    // Flags
    reg doneFlag;
    reg irqEnable;
    // Sequencer
    reg [1:0] state;
    reg [1:0] next_state;
    reg [4:0] tadCount;
    reg [4:0] next_count;
    // Bus
    reg ack;
    reg [7:0] rdByte;

    wire access;
    wire wrEn;
    wire laneZero;
    wire tadTick;
    wire sarStart;
    wire sarAbort;
    wire convDone;
    wire [9:0] sarResult;
    wire [15:0] formatted;

    function [4:0] acqTads;
        input [2:0] code;
        begin
            case (code)
                3'h0: acqTads = `ADCSEQ_ACQ_T0;
                3'h1: acqTads = `ADCSEQ_ACQ_T1;
                3'h2: acqTads = `ADCSEQ_ACQ_T2;
                3'h3: acqTads = `ADCSEQ_ACQ_T3;
                3'h4: acqTads = `ADCSEQ_ACQ_T4;
                3'h5: acqTads = `ADCSEQ_ACQ_T5;
                3'h6: acqTads = `ADCSEQ_ACQ_T6;
                default: acqTads = `ADCSEQ_ACQ_T7;
            endcase
        end
    endfunction

    function [15:0] placeResult;
        input [9:0] value;
        input right;
        begin
            if (right) begin
                placeResult = {6'h00, value[9:8], value[7:0]};
            end else begin
                placeResult = {value[9:2], value[1:0], 6'h00};
            end
        end
    endfunction

    // One wait state per access keeps read data registered
    assign access = avsRead | avsWrite;
    assign avsWaitrequest = access & ~ack;
    assign wrEn = avsWrite & ack;
    assign laneZero = avsByteenable[0];

    assign channelSelect = chanSel;
    assign portConfig = cfgBits;

    assign formatted = placeResult(sarResult, fmtRight);

    always @(posedge mclk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= access & ~ack;
        end
    end

    always @* begin
        rdByte = 8'h00;
        case (avsAddress)
            `ADCSEQ_OFS_CTRL0: begin
                rdByte[`ADCSEQ_B_ON] = converterOn;
                rdByte[`ADCSEQ_B_GO] = goFlag;
                rdByte[`ADCSEQ_F_CHAN] = chanSel;
            end
            `ADCSEQ_OFS_CTRL1: begin
                rdByte[`ADCSEQ_F_CFG] = cfgBits;
            end
            `ADCSEQ_OFS_CTRL2: begin
                rdByte[`ADCSEQ_B_FMT] = fmtRight;
                rdByte[`ADCSEQ_B_UNUSED] = 1'b0;
                rdByte[`ADCSEQ_F_ACQ] = acqSel;
                rdByte[`ADCSEQ_F_CS] = clkSel;
            end
            `ADCSEQ_OFS_RESH: begin
                rdByte = resHigh;
            end
            `ADCSEQ_OFS_RESL: begin
                rdByte = resLow;
            end
            `ADCSEQ_OFS_FLAGS: begin
                rdByte[`ADCSEQ_B_DONE] = doneFlag;
                rdByte[`ADCSEQ_B_IRQEN] = irqEnable;
            end
            default: begin
                rdByte = 8'h00;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            avsReaddata <= 32'h00000000;
        end else if (avsRead && !ack) begin
            avsReaddata <= {24'h000000, rdByte};
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            converterOn <= 1'b0;
            chanSel <= `ADCSEQ_CHAN_RST;
            cfgBits <= `ADCSEQ_CFG_RST;
            fmtRight <= 1'b0;
            acqSel <= `ADCSEQ_ACQ_RST;
            clkSel <= `ADCSEQ_CS_RST;
            irqEnable <= 1'b0;
        end else if (wrEn && laneZero) begin
            case (avsAddress)
                `ADCSEQ_OFS_CTRL0: begin
                    converterOn <= avsWritedata[`ADCSEQ_B_ON];
                    chanSel <= avsWritedata[`ADCSEQ_F_CHAN];
                end
                `ADCSEQ_OFS_CTRL1: begin
                    cfgBits <= avsWritedata[`ADCSEQ_F_CFG];
                end
                `ADCSEQ_OFS_CTRL2: begin
                    fmtRight <= avsWritedata[`ADCSEQ_B_FMT];
                    acqSel <= avsWritedata[`ADCSEQ_F_ACQ];
                    clkSel <= avsWritedata[`ADCSEQ_F_CS];
                end
                `ADCSEQ_OFS_FLAGS: begin
                    irqEnable <= avsWritedata[`ADCSEQ_B_IRQEN];
                end
                default: begin
                    irqEnable <= irqEnable;
                end
            endcase
        end
    end

    // Go needs the converter already on; same-write enable is ignored
    always @(posedge mclk) begin
        if (rst) begin
            goFlag <= 1'b0;
        end else if (!converterOn) begin
            goFlag <= 1'b0;
        end else if (convDone) begin
            goFlag <= 1'b0;
        end else if (wrEn && laneZero && avsAddress == `ADCSEQ_OFS_CTRL0) begin
            goFlag <= avsWritedata[`ADCSEQ_B_GO] & avsWritedata[`ADCSEQ_B_ON];
        end else if (specialEventTrigger) begin
            goFlag <= 1'b1;
        end
    end

    // Completion beats a same-cycle write-one clear
    always @(posedge mclk) begin
        if (rst) begin
            doneFlag <= 1'b0;
        end else if (convDone) begin
            doneFlag <= 1'b1;
        end else if (wrEn && laneZero && avsAddress == `ADCSEQ_OFS_FLAGS) begin
            doneFlag <= doneFlag & ~avsWritedata[`ADCSEQ_B_DONE];
        end
    end

    always @(posedge mclk) begin
        if (convDone) begin
            resHigh <= formatted[15:8];
            resLow <= formatted[7:0];
        end else if (wrEn && laneZero && avsAddress == `ADCSEQ_OFS_RESH) begin
            resHigh <= avsWritedata[7:0];
        end else if (wrEn && laneZero && avsAddress == `ADCSEQ_OFS_RESL) begin
            resLow <= avsWritedata[7:0];
        end
    end

    always @* begin
        next_state = state;
        next_count = tadCount;
        case (state)
            ST_IDLE: begin
                next_count = 5'h00;
                if (goFlag) begin
                    if (acqSel == `ADCSEQ_ACQ_MANUAL) begin
                        next_state = ST_CONV;
                    end else begin
                        next_state = ST_ACQ;
                    end
                end
            end
            ST_ACQ: begin
                if (!goFlag) begin
                    next_state = ST_WAIT;
                    next_count = 5'h00;
                end else if (tadTick) begin
                    if (tadCount + 5'h01 == acqTads(acqSel)) begin
                        next_state = ST_CONV;
                        next_count = 5'h00;
                    end else begin
                        next_count = tadCount + 5'h01;
                    end
                end
            end
            ST_CONV: begin
                if (convDone || !goFlag) begin
                    next_state = ST_WAIT;
                    next_count = 5'h00;
                end
            end
            ST_WAIT: begin
                if (tadTick) begin
                    if (tadCount == `ADCSEQ_WAIT_LAST) begin
                        next_state = ST_IDLE;
                        next_count = 5'h00;
                    end else begin
                        next_count = tadCount + 5'h01;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_count = 5'h00;
            end
        endcase
        if (!converterOn) begin
            next_state = ST_IDLE;
            next_count = 5'h00;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
            tadCount <= 5'h00;
            sampleEnable <= 1'b0;
        end else begin
            state <= next_state;
            tadCount <= next_count;
            sampleEnable <= converterOn & (next_state == ST_IDLE || next_state == ST_ACQ);
        end
    end

    assign sarStart = (state != ST_CONV) && (next_state == ST_CONV);
    assign sarAbort = (state == ST_CONV) && (next_state != ST_CONV) && !convDone;

    adcseq_tad_gen u_tad (
        .mclk(mclk),
        .rst(rst),
        .run(state != ST_IDLE),
        .clkSel(clkSel),
        .sleepActive(sleepActive),
        .rcTick(rcTick),
        .tadTick(tadTick)
    );

    adcseq_sar u_sar (
        .mclk(mclk),
        .rst(rst),
        .start(sarStart),
        .abort(sarAbort),
        .tadTick(tadTick),
        .compIn(compIn),
        .dacCode(dacCode),
        .result(sarResult),
        .done(convDone)
    );

endmodule

// ==== shared/adcseq_defines.vh ====
`ifndef ADCSEQ_DEFINES_VH
`define ADCSEQ_DEFINES_VH

// Register byte offsets
`define ADCSEQ_AW 5
`define ADCSEQ_OFS_CTRL0 5'h00
`define ADCSEQ_OFS_CTRL1 5'h04
`define ADCSEQ_OFS_CTRL2 5'h08
`define ADCSEQ_OFS_RESH 5'h0c
`define ADCSEQ_OFS_RESL 5'h10
`define ADCSEQ_OFS_FLAGS 5'h14

// Control zero fields
`define ADCSEQ_B_ON 0
`define ADCSEQ_B_GO 1
`define ADCSEQ_F_CHAN 5:2
// Control one fields
`define ADCSEQ_F_CFG 5:0
// Control two fields
`define ADCSEQ_B_FMT 7
`define ADCSEQ_B_UNUSED 6
`define ADCSEQ_F_ACQ 5:3
`define ADCSEQ_F_CS 2:0
// Flag register fields
`define ADCSEQ_B_DONE 0
`define ADCSEQ_B_IRQEN 1

// Reset values
`define ADCSEQ_CHAN_RST 4'h0
`define ADCSEQ_CFG_RST 6'h00
`define ADCSEQ_ACQ_RST 3'h0
`define ADCSEQ_CS_RST 3'h0
`define ADCSEQ_SAR_RST 10'h000

// Acquisition lengths in conversion clock periods
`define ADCSEQ_ACQ_MANUAL 3'h0
`define ADCSEQ_ACQ_T0 5'h00
`define ADCSEQ_ACQ_T1 5'h02
`define ADCSEQ_ACQ_T2 5'h04
`define ADCSEQ_ACQ_T3 5'h06
`define ADCSEQ_ACQ_T4 5'h08
`define ADCSEQ_ACQ_T5 5'h0c
`define ADCSEQ_ACQ_T6 5'h10
`define ADCSEQ_ACQ_T7 5'h14

// Conversion clock dividers
`define ADCSEQ_DIV2 7'h02
`define ADCSEQ_DIV4 7'h04
`define ADCSEQ_DIV8 7'h08
`define ADCSEQ_DIV16 7'h10
`define ADCSEQ_DIV32 7'h20
`define ADCSEQ_DIV64 7'h40
`define ADCSEQ_CS_RC 2'h3

// Sequencing counts
`define ADCSEQ_CONV_LAST 4'ha
`define ADCSEQ_WAIT_LAST 5'h01
`define ADCSEQ_SAR_MSB 10'h200

// Instruction cycle delay before the RC clock
`define ADCSEQ_MCLK_MHZ 40
`define ADCSEQ_TOSC_NS 25
`define ADCSEQ_TCY_NS (4 * `ADCSEQ_TOSC_NS)
`define ADCSEQ_TCY_CYCLES ((`ADCSEQ_TCY_NS * `ADCSEQ_MCLK_MHZ + 999) / 1000)

`endif

// ==== rtl/adcseq_tad_gen.v ====
`timescale 1ns/1ps
`include "adcseq_defines.vh"

module adcseq_tad_gen (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Control
    input wire run,
    input wire [2:0] clkSel,
    input wire sleepActive,
    input wire rcTick,
    // Conversion clock enable
    output reg tadTick
);

    localparam integer TCY_FULL = `ADCSEQ_TCY_CYCLES;
    localparam [2:0] TCY_COUNT = TCY_FULL[2:0];

    reg [6:0] divCnt;
    reg [2:0] rcDelay;
    wire useRc;

    function [6:0] divisor;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: divisor = `ADCSEQ_DIV2;
                3'h1: divisor = `ADCSEQ_DIV8;
                3'h2: divisor = `ADCSEQ_DIV32;
                3'h4: divisor = `ADCSEQ_DIV4;
                3'h5: divisor = `ADCSEQ_DIV16;
                3'h6: divisor = `ADCSEQ_DIV64;
                default: divisor = `ADCSEQ_DIV2;
            endcase
        end
    endfunction

    assign useRc = (clkSel[1:0] == `ADCSEQ_CS_RC);

    always @(posedge mclk) begin
        if (rst || !run) begin
            divCnt <= 7'h00;
            rcDelay <= 3'h0;
            tadTick <= 1'b0;
        end else begin
            tadTick <= 1'b0;
            if (useRc) begin
                if (rcDelay != TCY_COUNT) begin
                    rcDelay <= rcDelay + 3'h1;
                end else if (rcTick) begin
                    tadTick <= 1'b1;
                end
            end else if (!sleepActive) begin
                if (divCnt == divisor(clkSel) - 7'h01) begin
                    divCnt <= 7'h00;
                    tadTick <= 1'b1;
                end else begin
                    divCnt <= divCnt + 7'h01;
                end
            end
        end
    end

endmodule

// ==== rtl/adcseq_sar.v ====
`timescale 1ns/1ps
`include "adcseq_defines.vh"

module adcseq_sar (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Sequencer control
    input wire start,
    input wire abort,
    input wire tadTick,
    // Comparator side
    input wire compIn,
    output reg [9:0] dacCode,
    // Result
    output reg [9:0] result,
    output reg done
);

    reg busy;
    reg [3:0] step;
    reg [9:0] mask;
    wire [9:0] nextCode;

    assign nextCode = (dacCode & ~mask) | (compIn ? mask : 10'h000) | (mask >> 1);

    always @(posedge mclk) begin
        if (rst) begin
            busy <= 1'b0;
            step <= 4'h0;
            mask <= `ADCSEQ_SAR_RST;
            dacCode <= `ADCSEQ_SAR_RST;
            result <= `ADCSEQ_SAR_RST;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy <= 1'b1;
                step <= 4'h0;
                mask <= `ADCSEQ_SAR_MSB;
                dacCode <= `ADCSEQ_SAR_MSB;
            end else if (abort) begin
                busy <= 1'b0;
            end else if (busy && tadTick) begin
                step <= step + 4'h1;
                // First period settles the held sample
                if (step != 4'h0) begin
                    dacCode <= nextCode;
                    mask <= mask >> 1;
                end
                if (step == `ADCSEQ_CONV_LAST) begin
                    busy <= 1'b0;
                    result <= nextCode;
                    done <= 1'b1;
                end
            end
        end
    end

endmodule

// ==== verif/adcseq_afe_model.sv ====
`timescale 1ns/1ps

module adcseq_afe_model (
    // Clock
    input wire mclk,
    // Front end
    input wire sampleEnable,
    input wire [3:0] channelSelect,
    input wire [9:0] dacCode,
    output wire compIn
);
    // Level per channel, distinct on every channel
    reg [9:0] held = 10'h000;
    always @(posedge mclk) begin
        if (sampleEnable) begin
            held <= {channelSelect, 6'h00} ^ {4'h0, channelSelect, 2'h3};
        end
    end
    assign compIn = (held >= dacCode);
endmodule

// ==== verif/adcseq_top_sva.sv ====
`timescale 1ns/1ps
`include "adcseq_defines.vh"

module adcseq_top_sva (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Bus
    input wire [4:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWritedata,
    input wire [3:0] avsByteenable,
    input wire [31:0] avsReaddata,
    input wire avsWaitrequest,
    // Front end
    input wire sampleEnable,
    input wire [3:0] channelSelect,
    input wire [9:0] dacCode,
    input wire compIn,
    input wire [5:0] portConfig,
    input wire sleepActive,
    input wire rcTick,
    input wire specialEventTrigger
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Shadow of the on bit, seen from bus writes
    reg onShadow;
    always @(posedge mclk) begin
        if (rst) begin
            onShadow <= 1'b0;
        end else if (avsWrite && !avsWaitrequest && avsByteenable[0]
                     && avsAddress == `ADCSEQ_OFS_CTRL0) begin
            onShadow <= avsWritedata[0];
        end
    end
    a_one_wait: assert property ($rose(avsRead | avsWrite) |-> avsWaitrequest ##1 !avsWaitrequest)
        else $error("bus wait state count wrong");
    a_idle_nowait: assert property (!(avsRead | avsWrite) |-> !avsWaitrequest)
        else $error("waitrequest without request");
    a_upper_zero: assert property (avsReaddata[31:8] == 24'h000000)
        else $error("readdata upper bits set");
    a_rst_quiet: assert property (disable iff (1'b0) rst |=> !sampleEnable && dacCode == 10'h000
        && channelSelect == 4'h0 && portConfig == 6'h00) else $error("reset state wrong");
    a_off_idle: assert property (!onShadow && !$past(onShadow) && !$past(onShadow, 2)
        |-> !sampleEnable) else $error("sampling while off");
    a_dac_held: assert property ($changed(dacCode) && dacCode != 10'h000 |-> !sampleEnable)
        else $error("trial code moved while sampling");
    a_conv_low: assert property ($fell(sampleEnable) |=> !sampleEnable [*4])
        else $error("sampling resumed too soon");
    a_bit6_zero: assert property (avsRead && !avsWaitrequest && avsAddress == `ADCSEQ_OFS_CTRL2
        |-> avsReaddata[6] == 1'b0) else $error("unused bit reads one");
    a_unmapped_zero: assert property (avsRead && !avsWaitrequest && avsAddress > 5'h14
        |-> avsReaddata == 32'h00000000) else $error("unmapped read not zero");
endmodule

bind adcseq_top adcseq_top_sva adcseq_top_sva_inst (.mclk(mclk), .rst(rst),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .sampleEnable(sampleEnable),
    .channelSelect(channelSelect), .dacCode(dacCode), .compIn(compIn),
    .portConfig(portConfig), .sleepActive(sleepActive), .rcTick(rcTick),
    .specialEventTrigger(specialEventTrigger));

// ==== verif/adcseq_top_tb_top.sv ====
`timescale 1ns/1ps
`include "adcseq_defines.vh"

module adcseq_top_tb_top;
    reg mclk = 1'b0;
    reg rst = 1'b1;
    reg [4:0] avsAddress = 5'h00;
    reg avsRead = 1'b0;
    reg avsWrite = 1'b0;
    reg [31:0] avsWritedata = 32'h0;
    reg [3:0] avsByteenable = 4'h1;
    reg sleepActive = 1'b0;
    reg rcTick = 1'b0;
    reg specialEventTrigger = 1'b0;
    reg [2:0] rcCnt = 3'h0;
    wire [31:0] avsReaddata;
    wire avsWaitrequest;
    wire sampleEnable;
    wire compIn;
    wire [3:0] channelSelect;
    wire [9:0] dacCode;
    wire [5:0] portConfig;
    integer n_fail = 0;
    integer total_checks = 0;
    integer i, cyc, n, a;
    reg [31:0] rd;
    reg [3:0] ch;
    reg [9:0] lv;
    reg [7:0] expH, expL;

    always #12.5 mclk = ~mclk;
    // RC period of six clocks, slower than the fastest divider
    always @(posedge mclk) begin
        rcCnt <= (rcCnt == 3'h5) ? 3'h0 : rcCnt + 3'h1;
        rcTick <= (rcCnt == 3'h5);
    end

    adcseq_top adcseq_top_inst (.mclk(mclk), .rst(rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .sampleEnable(sampleEnable),
        .channelSelect(channelSelect), .dacCode(dacCode), .compIn(compIn),
        .portConfig(portConfig), .sleepActive(sleepActive), .rcTick(rcTick),
        .specialEventTrigger(specialEventTrigger));
    adcseq_afe_model adcseq_afe_model_inst (.mclk(mclk), .sampleEnable(sampleEnable),
        .channelSelect(channelSelect), .dacCode(dacCode), .compIn(compIn));

    // Entered just after a rising edge; leaves one idle edge so strobes never double up
    task busXfer(input wr, input [4:0] adr, input [7:0] d);
        reg waitHi;
        begin
            avsAddress <= adr;
            avsWritedata <= {24'h000000, d};
            avsWrite <= wr;
            avsRead <= !wr;
            waitHi = 1'b1;
            // Settled value before each rising edge decides that edge
            while (waitHi) begin
                @(negedge mclk);
                waitHi = (avsWaitrequest !== 1'b0);
                rd = avsReaddata;
                @(posedge mclk);
            end
            avsWrite <= 1'b0;
            avsRead <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task checkVal(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task checkRange(input integer got, input integer lo, input integer hi);
        begin
            total_checks = total_checks + 1;
            if (got < lo || got > hi) begin
                n_fail = n_fail + 1;
                $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
            end
        end
    endtask
    task waitSample(input v);
        begin
            cyc = 0;
            @(negedge mclk);
            while (sampleEnable !== v) begin
                @(negedge mclk);
                cyc = cyc + 1;
            end
            @(posedge mclk);
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    function integer divOf(input [2:0] cs);
        case (cs)
            3'h0: divOf = 2;
            3'h1: divOf = 8;
            3'h2: divOf = 32;
            3'h4: divOf = 4;
            3'h5: divOf = 16;
            3'h6: divOf = 64;
            default: divOf = 6;
        endcase
    endfunction
    function integer acqOf(input [2:0] c);
        case (c)
            3'h5: acqOf = 12;
            3'h6: acqOf = 16;
            3'h7: acqOf = 20;
            default: acqOf = 2 * c;
        endcase
    endfunction

    initial begin
        repeat (60000) @(posedge mclk);
        n_fail = n_fail + 1;
        $display("watchdog expired");
        summarize;
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        busXfer(0, `ADCSEQ_OFS_CTRL0, 8'h00);
        checkVal(rd, 32'h0);
        busXfer(0, `ADCSEQ_OFS_CTRL2, 8'h00);
        checkVal(rd, 32'h0);
        avsByteenable <= 4'h0;
        busXfer(1, `ADCSEQ_OFS_CTRL1, 8'h3f);
        avsByteenable <= 4'h1;
        busXfer(0, `ADCSEQ_OFS_CTRL1, 8'h00);
        checkVal(rd, 32'h0);
        busXfer(1, `ADCSEQ_OFS_CTRL2, 8'hff);
        busXfer(0, `ADCSEQ_OFS_CTRL2, 8'h00);
        checkVal(rd, 32'hbf);
        busXfer(1, 5'h18, 8'h5a);
        busXfer(0, 5'h18, 8'h00);
        checkVal(rd, 32'h0);
        $display("register test done");
        // Every acquisition and clock code once, both formats
        for (i = 0; i < 8; i = i + 1) begin
            ch = (i * 3) % 13;
            lv = {ch, 6'h00} ^ {4'h0, ch, 2'h3};
            n = divOf(i);
            a = acqOf(i);
            sleepActive <= (i % 4 == 3);
            busXfer(1, `ADCSEQ_OFS_CTRL1, i[7:0]);
            checkVal({26'h0000000, portConfig}, i);
            busXfer(1, `ADCSEQ_OFS_CTRL2, {i[0], 1'b0, i[2:0], i[2:0]});
            busXfer(1, `ADCSEQ_OFS_CTRL0, {2'b00, ch, 2'b01});
            busXfer(1, `ADCSEQ_OFS_CTRL0, {2'b00, ch, 2'b11});
            waitSample(0);
            checkRange(cyc, a * n - 2, a * n + n + 12);
            busXfer(0, `ADCSEQ_OFS_CTRL0, 8'h00);
            checkVal(rd[1], 1'b1);
            waitSample(1);
            checkRange(cyc, 13 * n - 4, 14 * n + 12);
            busXfer(0, `ADCSEQ_OFS_CTRL0, 8'h00);
            checkVal(rd, {24'h000000, 2'b00, ch, 2'b01});
            busXfer(0, `ADCSEQ_OFS_FLAGS, 8'h00);
            checkVal(rd[0], 1'b1);
            expH = i[0] ? {6'h00, lv[9:8]} : lv[9:2];
            expL = i[0] ? lv[7:0] : {lv[1:0], 6'h00};
            busXfer(0, `ADCSEQ_OFS_RESH, 8'h00);
            checkVal(rd, expH);
            busXfer(0, `ADCSEQ_OFS_RESL, 8'h00);
            checkVal(rd, expL);
            busXfer(1, `ADCSEQ_OFS_FLAGS, 8'h03);
            busXfer(0, `ADCSEQ_OFS_FLAGS, 8'h00);
            checkVal(rd, 32'h2);
        end
        $display("conversion test done");
        sleepActive <= 1'b0;
        busXfer(1, `ADCSEQ_OFS_CTRL2, 8'h06);
        busXfer(1, `ADCSEQ_OFS_CTRL0, 8'h15);
        busXfer(1, `ADCSEQ_OFS_CTRL0, 8'h17);
        repeat (100) @(posedge mclk);
        busXfer(1, `ADCSEQ_OFS_CTRL0, 8'h15);
        waitSample(1);
        busXfer(0, `ADCSEQ_OFS_RESH, 8'h00);
        checkVal(rd, expH);
        busXfer(0, `ADCSEQ_OFS_FLAGS, 8'h00);
        checkVal(rd[0], 1'b0);
        $display("abort test done");
        // Divide-by-2 conversion clock stalls while asleep
        busXfer(1, `ADCSEQ_OFS_CTRL2, 8'h00);
        sleepActive <= 1'b1;
        busXfer(1, `ADCSEQ_OFS_CTRL0, 8'h17);
        repeat (200) @(posedge mclk);
        busXfer(0, `ADCSEQ_OFS_CTRL0, 8'h00);
        checkVal(rd[1], 1'b1);
        sleepActive <= 1'b0;
        waitSample(1);
        busXfer(0, `ADCSEQ_OFS_RESH, 8'h00);
        checkVal(rd, 32'h55);
        $display("sleep test done");
        busXfer(1, `ADCSEQ_OFS_CTRL0, 8'h00);
        specialEventTrigger <= 1'b1;
        @(posedge mclk);
        specialEventTrigger <= 1'b0;
        busXfer(0, `ADCSEQ_OFS_CTRL0, 8'h00);
        checkVal(rd, 32'h0);
        busXfer(1, `ADCSEQ_OFS_CTRL0, 8'h01);
        specialEventTrigger <= 1'b1;
        @(posedge mclk);
        specialEventTrigger <= 1'b0;
        busXfer(0, `ADCSEQ_OFS_CTRL0, 8'h00);
        checkVal(rd, 32'h3);
        // Reset in mid conversion
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        busXfer(0, `ADCSEQ_OFS_CTRL0, 8'h00);
        checkVal(rd, 32'h0);
        busXfer(0, `ADCSEQ_OFS_RESH, 8'h00);
        checkVal(rd, 32'h55);
        $display("trigger and reset test done");
        summarize;
    end
endmodule
